// [hdl/uap_core.sv]
// serial unit top: cpu registers, power sequencing, transmitter
// assumes base_tick_i marks one falling edge of the chosen base clock
module uap_core
(
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic [15:0] bus_addr_i,
	input  wire logic        bus_write_i,
	input  wire logic        bus_read_i,
	input  wire logic [7:0]  bus_wdata_i,
	output logic [7:0]       bus_rdata_o,
	input  wire logic        base_tick_i,
	input  wire logic [7:0]  baud_divisor_i,
	input  wire logic        msb_first_i,
	input  wire logic        serial_in_i,
	output logic             serial_out_o,
	output logic             receive_done_irq_o,
	output logic             receive_error_irq_o,
	output logic             transmit_done_irq_o
);

	////////////////////////////////////////////////////////////////////////
	// registers and decode
	logic [7:0] operation_mode_reg;
	logic [7:0] transmit_buffer_reg;
	logic [7:0] receive_buffer_reg;
	logic [2:0] receive_error_status_reg;
	logic       tx_buffer_full_reg;
	logic       rx_unread_reg;
	logic [7:0] rdata_reg;
	logic [1:0] power_ticks_reg;
	logic       unit_power;
	logic       transmit_enable;
	logic       receive_enable;
	logic [1:0] parity_mode;
	logic       counter_on;
	logic       tx_active;
	logic       rx_active;
	logic       wr_mode;
	logic       wr_txbuf;
	logic       rd_rxbuf;
	logic       rd_err;
	logic       rx_line;
	logic       rx_done;
	logic [7:0] rx_data;
	logic       rx_perr;
	logic       rx_ferr;
	logic       overrun;
	logic       any_err;
	logic       rx_irq_reg;
	logic       rx_err_irq_reg;
	logic       tx_busy;

	assign unit_power      = operation_mode_reg[uap_pkg::MODE_UNIT_POWER];
	assign transmit_enable = operation_mode_reg[uap_pkg::MODE_TRANSMIT_ENABLE];
	assign receive_enable  = operation_mode_reg[uap_pkg::MODE_RECEIVE_ENABLE];
	assign parity_mode     = {operation_mode_reg[uap_pkg::MODE_PARITY_SELECT_HI],
		operation_mode_reg[uap_pkg::MODE_PARITY_SELECT_LO]};
	assign counter_on      = (power_ticks_reg == uap_pkg::POWER_START_TICKS);
	assign tx_active       = counter_on && transmit_enable;
	assign rx_active       = counter_on && receive_enable;

	assign wr_mode  = bus_write_i && (bus_addr_i == uap_pkg::OFS_OPERATION_MODE);
	assign wr_txbuf = bus_write_i && (bus_addr_i == uap_pkg::OFS_TRANSMIT_BUFFER);
	assign rd_rxbuf = bus_read_i && (bus_addr_i == uap_pkg::OFS_RECEIVE_BUFFER);
	assign rd_err   = bus_read_i && (bus_addr_i == uap_pkg::OFS_RECEIVE_ERROR_STATUS);

	assign rx_line  = unit_power ? serial_in_i : 1'b1;

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			operation_mode_reg <= uap_pkg::RST_OPERATION_MODE;
		else if (wr_mode)
			operation_mode_reg <= bus_wdata_i;
	end

	// internal clock gate: counter runs from the third base tick, after two ticks have passed
	always_ff @(posedge clk_i)
	begin
		if (reset_i || !unit_power)
			power_ticks_reg <= 2'h0;
		else if (base_tick_i && !counter_on)
			power_ticks_reg <= power_ticks_reg + 2'h1;
	end

	////////////////////////////////////////////////////////////////////////
	// read port
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			rdata_reg <= 8'h00;
		else if (bus_read_i)
		begin
			case (bus_addr_i)
				uap_pkg::OFS_OPERATION_MODE:       rdata_reg <= operation_mode_reg;
				uap_pkg::OFS_TRANSMIT_BUFFER:      rdata_reg <= transmit_buffer_reg;
				uap_pkg::OFS_RECEIVE_BUFFER:       rdata_reg <= receive_buffer_reg;
				uap_pkg::OFS_RECEIVE_ERROR_STATUS:
					rdata_reg <= {5'h00, receive_error_status_reg};
				uap_pkg::OFS_TRANSMIT_STATUS:
					rdata_reg <= {6'h00, tx_buffer_full_reg, tx_busy};
				default:                           rdata_reg <= 8'h00;
			endcase
		end
	end

	assign bus_rdata_o = rdata_reg;

	////////////////////////////////////////////////////////////////////////
	// receive path
	uap_rx u_rx
	(
		.clk_i        (clk_i),
		.reset_i      (reset_i),
		.active_i     (rx_active),
		.base_tick_i  (base_tick_i),
		.divisor_i    (baud_divisor_i),
		.line_i       (rx_line),
		.char_len_i   (operation_mode_reg[uap_pkg::MODE_CHAR_LENGTH]),
		.parity_i     (parity_mode),
		.msb_first_i  (msb_first_i),
		.done_o       (rx_done),
		.data_o       (rx_data),
		.parity_err_o (rx_perr),
		.frame_err_o  (rx_ferr)
	);

	assign overrun = rx_done && rx_unread_reg;
	assign any_err = rx_perr || rx_ferr || overrun;

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			receive_buffer_reg <= uap_pkg::RST_BUFFER;
		else if (!unit_power)
			receive_buffer_reg <= uap_pkg::RST_BUFFER;
		else if (rx_done && !overrun)
			receive_buffer_reg <= rx_data;
	end

	// unread marker: a new character wins over a read in the same cycle
	always_ff @(posedge clk_i)
	begin
		if (reset_i || !rx_active)
			rx_unread_reg <= 1'b0;
		else if (rx_done)
			rx_unread_reg <= 1'b1;
		else if (rd_rxbuf)
			rx_unread_reg <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i || !unit_power || !receive_enable)
			receive_error_status_reg <= uap_pkg::RST_STATUS[2:0];
		else if (rx_done)
			receive_error_status_reg <= (rd_err ? 3'h0 : receive_error_status_reg) |
				{rx_perr, rx_ferr, overrun};
		else if (rd_err)
			receive_error_status_reg <= 3'h0;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			rx_irq_reg     <= 1'b0;
			rx_err_irq_reg <= 1'b0;
		end
		else
		begin
			rx_irq_reg     <= rx_done &&
				(!any_err || operation_mode_reg[uap_pkg::MODE_ERROR_IRQ_ROUTING]);
			rx_err_irq_reg <= rx_done && any_err &&
				!operation_mode_reg[uap_pkg::MODE_ERROR_IRQ_ROUTING];
		end
	end

	assign receive_done_irq_o  = rx_irq_reg;
	assign receive_error_irq_o = rx_err_irq_reg;

	////////////////////////////////////////////////////////////////////////
	// transmit path
	uap_pkg::uap_tx_state_type tx_state_reg;
	logic [7:0] transmit_shifter_reg;
	logic [3:0] tx_count_reg;
	logic       tx_par_reg;
	logic       tx_stop_reg;
	logic       tx_out_reg;
	logic       tx_done_reg;
	logic       tx_bit_end;
	logic       tx_stop_last;
	logic       tx_frame_end;
	logic       tx_take;
	logic       tx_level;
	logic       tx_parity_bit;
	logic [3:0] tx_nbits;
	logic       tx_data_bit;

	assign tx_busy      = (tx_state_reg != uap_pkg::TX_IDLE);
	assign tx_nbits     = operation_mode_reg[uap_pkg::MODE_CHAR_LENGTH] ?
		uap_pkg::BITS_EIGHT : uap_pkg::BITS_SEVEN;
	assign tx_stop_last = !operation_mode_reg[uap_pkg::MODE_STOP_BIT_COUNT] ||
		tx_stop_reg;
	assign tx_frame_end = (tx_state_reg == uap_pkg::TX_STOP) && tx_bit_end && tx_stop_last;
	// load on a base tick: straight from idle, or at the end of the last stop bit
	assign tx_take      = tx_active && tx_buffer_full_reg && base_tick_i &&
		((tx_state_reg == uap_pkg::TX_IDLE) || tx_frame_end);
	assign tx_data_bit  = msb_first_i ? transmit_shifter_reg[7] : transmit_shifter_reg[0];

	always_comb
	begin
		case (parity_mode)
			uap_pkg::PARITY_ODD:  tx_parity_bit = !tx_par_reg;
			uap_pkg::PARITY_EVEN: tx_parity_bit = tx_par_reg;
			default:              tx_parity_bit = 1'b0;
		endcase
	end

	always_comb
	begin
		case (tx_state_reg)
			uap_pkg::TX_START:  tx_level = 1'b0;
			uap_pkg::TX_DATA:   tx_level = tx_data_bit;
			uap_pkg::TX_PARITY: tx_level = tx_parity_bit;
			default:            tx_level = 1'b1;
		endcase
	end

	uap_bit_timer u_tx_timer
	(
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.enable_i    (tx_active),
		.restart_i   (tx_take),
		.base_tick_i (base_tick_i),
		.divisor_i   (baud_divisor_i),
		.mid_o       (),
		.end_o       (tx_bit_end)
	);

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			transmit_buffer_reg <= uap_pkg::RST_BUFFER;
		else if (wr_txbuf)
			transmit_buffer_reg <= bus_wdata_i;
	end

	// a write in the load cycle keeps the flag set
	always_ff @(posedge clk_i)
	begin
		if (reset_i || !unit_power || !transmit_enable)
			tx_buffer_full_reg <= 1'b0;
		else if (wr_txbuf)
			tx_buffer_full_reg <= 1'b1;
		else if (tx_take)
			tx_buffer_full_reg <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i || !tx_active)
		begin
			tx_state_reg         <= uap_pkg::TX_IDLE;
			transmit_shifter_reg <= uap_pkg::RST_BUFFER;
			tx_count_reg         <= 4'h0;
			tx_par_reg           <= 1'b0;
			tx_stop_reg          <= 1'b0;
		end
		else if (tx_take)
		begin
			tx_state_reg         <= uap_pkg::TX_START;
			transmit_shifter_reg <= transmit_buffer_reg;
			tx_count_reg         <= 4'h0;
			tx_par_reg           <= 1'b0;
			tx_stop_reg          <= 1'b0;
		end
		else if (tx_bit_end)
		begin
			case (tx_state_reg)
				uap_pkg::TX_START:
					tx_state_reg <= uap_pkg::TX_DATA;
				uap_pkg::TX_DATA:
				begin
					tx_par_reg   <= tx_par_reg ^ tx_data_bit;
					tx_count_reg <= tx_count_reg + 4'h1;
					if (msb_first_i)
						transmit_shifter_reg <= {transmit_shifter_reg[6:0], 1'b0};
					else
						transmit_shifter_reg <= {1'b0, transmit_shifter_reg[7:1]};
					if (tx_count_reg == tx_nbits - 4'h1)
						tx_state_reg <= (parity_mode == uap_pkg::PARITY_NONE) ?
							uap_pkg::TX_STOP : uap_pkg::TX_PARITY;
				end
				uap_pkg::TX_PARITY:
					tx_state_reg <= uap_pkg::TX_STOP;
				uap_pkg::TX_STOP:
					if (tx_stop_last)
						tx_state_reg <= uap_pkg::TX_IDLE;
					else
						tx_stop_reg <= 1'b1;
				default:
					tx_state_reg <= uap_pkg::TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			tx_out_reg  <= 1'b1;
			tx_done_reg <= 1'b0;
		end
		else
		begin
			tx_out_reg  <= unit_power ? tx_level : 1'b1;
			tx_done_reg <= tx_active && base_tick_i && tx_frame_end;
		end
	end

	assign serial_out_o        = tx_out_reg;
	assign transmit_done_irq_o = tx_done_reg;

endmodule

// [hdl/uap_pkg.sv]
// constants, register map and state types of the serial unit
// assumes one clock, synchronous active-high reset, 8-bit cpu register port
package uap_pkg;

	////////////////////////////////////////////////////////////////////////
	// register map
	localparam logic [15:0] OFS_OPERATION_MODE       = 16'hff50;
	localparam logic [15:0] OFS_TRANSMIT_BUFFER      = 16'hff51;
	localparam logic [15:0] OFS_RECEIVE_BUFFER       = 16'hff52;
	localparam logic [15:0] OFS_RECEIVE_ERROR_STATUS = 16'hff53;
	localparam logic [15:0] OFS_TRANSMIT_STATUS      = 16'hff55;

	localparam logic [7:0]  RST_OPERATION_MODE       = 8'h01;
	localparam logic [7:0]  RST_BUFFER               = 8'hff;
	localparam logic [7:0]  RST_STATUS               = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int MODE_UNIT_POWER       = 7;
	localparam int MODE_TRANSMIT_ENABLE  = 6;
	localparam int MODE_RECEIVE_ENABLE   = 5;
	localparam int MODE_PARITY_SELECT_HI = 4;
	localparam int MODE_PARITY_SELECT_LO = 3;
	localparam int MODE_CHAR_LENGTH      = 2;
	localparam int MODE_STOP_BIT_COUNT   = 1;
	localparam int MODE_ERROR_IRQ_ROUTING = 0;

	localparam int ERR_PARITY_FLAG       = 2;
	localparam int ERR_FRAMING_FLAG      = 1;
	localparam int ERR_OVERRUN_FLAG      = 0;

	localparam int TXST_BUFFER_FULL      = 1;
	localparam int TXST_SHIFTER_BUSY     = 0;

	////////////////////////////////////////////////////////////////////////
	// encodings and counts
	localparam logic [1:0] PARITY_NONE   = 2'h0;
	localparam logic [1:0] PARITY_ZERO   = 2'h1;
	localparam logic [1:0] PARITY_ODD    = 2'h2;
	localparam logic [1:0] PARITY_EVEN   = 2'h3;

	localparam logic [3:0] BITS_SEVEN    = 4'h7;
	localparam logic [3:0] BITS_EIGHT    = 4'h8;

	localparam logic [1:0] POWER_START_TICKS = 2'h2;

	typedef enum logic [2:0] {
		TX_IDLE   = 3'h0,
		TX_START  = 3'h1,
		TX_DATA   = 3'h2,
		TX_PARITY = 3'h3,
		TX_STOP   = 3'h4
	} uap_tx_state_type;

	typedef enum logic [2:0] {
		RX_IDLE   = 3'h0,
		RX_START  = 3'h1,
		RX_DATA   = 3'h2,
		RX_PARITY = 3'h3,
		RX_STOP   = 3'h4
	} uap_rx_state_type;

endpackage

// [hdl/uap_bit_timer.sv]
// bit period timer counting base ticks
// assumes divisor of zero means 256 ticks
module uap_bit_timer
(
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       enable_i,
	input  wire logic       restart_i,
	input  wire logic       base_tick_i,
	input  wire logic [7:0] divisor_i,
	output logic            mid_o,
	output logic            end_o
);

	logic [7:0] count_reg;
	logic [7:0] last_count;

	assign last_count = divisor_i - 8'h01;
	assign end_o      = base_tick_i && (count_reg == last_count);
	assign mid_o      = base_tick_i && (count_reg == {1'b0, divisor_i[7:1]});

	always_ff @(posedge clk_i)
	begin
		if (reset_i || !enable_i || restart_i)
			count_reg <= 8'h00;
		else if (end_o)
			count_reg <= 8'h00;
		else if (base_tick_i)
			count_reg <= count_reg + 8'h01;
	end

endmodule

// [hdl/uap_rx.sv]
// receive shifter: start detect, mid-bit sampling, parity and stop check
// assumes line_i already forced high while the unit is unpowered
module uap_rx
(
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       active_i,
	input  wire logic       base_tick_i,
	input  wire logic [7:0] divisor_i,
	input  wire logic       line_i,
	input  wire logic       char_len_i,
	input  wire logic [1:0] parity_i,
	input  wire logic       msb_first_i,
	output logic            done_o,
	output logic [7:0]      data_o,
	output logic            parity_err_o,
	output logic            frame_err_o
);

	uap_pkg::uap_rx_state_type state_reg;
	logic [7:0] receive_shifter_reg;
	logic [3:0] count_reg;
	logic       par_reg;
	logic       perr_reg;
	logic       done_reg;
	logic [7:0] data_reg;
	logic       perr_out_reg;
	logic       ferr_reg;
	logic       restart;
	logic       sample;
	logic [3:0] nbits;
	logic [7:0] aligned;

	assign restart = (state_reg == uap_pkg::RX_IDLE) && base_tick_i && !line_i;
	assign nbits   = char_len_i ? uap_pkg::BITS_EIGHT : uap_pkg::BITS_SEVEN;

	always_comb
	begin
		if (char_len_i)
			aligned = receive_shifter_reg;
		else if (msb_first_i)
			aligned = {receive_shifter_reg[6:0], 1'b0};
		else
			aligned = {1'b0, receive_shifter_reg[7:1]};
	end

	uap_bit_timer u_timer
	(
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.enable_i    (active_i),
		.restart_i   (restart),
		.base_tick_i (base_tick_i),
		.divisor_i   (divisor_i),
		.mid_o       (sample),
		.end_o       ()
	);

	always_ff @(posedge clk_i)
	begin
		done_reg <= 1'b0;
		if (reset_i || !active_i)
		begin
			state_reg           <= uap_pkg::RX_IDLE;
			receive_shifter_reg <= uap_pkg::RST_BUFFER;
			count_reg           <= 4'h0;
			par_reg             <= 1'b0;
			perr_reg            <= 1'b0;
		end
		else
		begin
			case (state_reg)
				uap_pkg::RX_IDLE:
					if (restart)
						state_reg <= uap_pkg::RX_START;
				uap_pkg::RX_START:
					if (sample)
					begin
						state_reg <= line_i ? uap_pkg::RX_IDLE : uap_pkg::RX_DATA;
						count_reg <= 4'h0;
						par_reg   <= 1'b0;
						perr_reg  <= 1'b0;
					end
				uap_pkg::RX_DATA:
					if (sample)
					begin
						if (msb_first_i)
							receive_shifter_reg <= {receive_shifter_reg[6:0], line_i};
						else
							receive_shifter_reg <= {line_i, receive_shifter_reg[7:1]};
						par_reg   <= par_reg ^ line_i;
						count_reg <= count_reg + 4'h1;
						if (count_reg == nbits - 4'h1)
							state_reg <= (parity_i == uap_pkg::PARITY_NONE) ?
								uap_pkg::RX_STOP : uap_pkg::RX_PARITY;
					end
				uap_pkg::RX_PARITY:
					if (sample)
					begin
						state_reg <= uap_pkg::RX_STOP;
						case (parity_i)
							uap_pkg::PARITY_ODD:  perr_reg <= !(par_reg ^ line_i);
							uap_pkg::PARITY_EVEN: perr_reg <= par_reg ^ line_i;
							default:              perr_reg <= 1'b0;
						endcase
					end
				uap_pkg::RX_STOP:
					if (sample)
					begin
						state_reg <= uap_pkg::RX_IDLE;
						done_reg  <= 1'b1;
					end
				default:
					state_reg <= uap_pkg::RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			data_reg     <= uap_pkg::RST_BUFFER;
			perr_out_reg <= 1'b0;
			ferr_reg     <= 1'b0;
		end
		else if (active_i && state_reg == uap_pkg::RX_STOP && sample)
		begin
			data_reg     <= aligned;
			perr_out_reg <= perr_reg;
			ferr_reg     <= !line_i;
		end
	end

	assign done_o       = done_reg;
	assign data_o       = data_reg;
	assign parity_err_o = perr_out_reg;
	assign frame_err_o  = ferr_reg;

endmodule

// [testbench/uap_node_model.sv]
// remote serial node: drives the receive line, captures the transmit line
// assumes a bit time of BIT_CLKS clocks and an idle-high line
module uap_node_model
#(
	parameter int BIT_CLKS = 8
)
(
	input  wire logic clk_i,
	input  wire logic line_i,
	output logic      line_o
);
	initial line_o = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// one frame out, low bit first in the vector
	task automatic send_bits(input logic [11:0] bits, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk_i);
			#1;
			line_o = bits[i];
			repeat (BIT_CLKS - 1) @(posedge clk_i);
		end
		@(posedge clk_i);
		#1;
		line_o = 1'b1;
	endtask

	////////////////////////////////////////////////////////////////////////
	// one frame in, sampled mid-bit; returns right after the last sample
	task automatic recv_bits(input int n, output logic [11:0] bits, output logic ok);
		int t;
		bits = 12'hfff;
		t = 0;
		while (line_i !== 1'b0 && t < 400)
		begin
			@(posedge clk_i);
			t++;
		end
		ok = (t < 400);
		repeat (BIT_CLKS / 2) @(posedge clk_i);
		for (int i = 0; i < n; i++)
		begin
			if (i > 0)
				repeat (BIT_CLKS) @(posedge clk_i);
			bits[i] = line_i;
		end
	endtask
endmodule

// [testbench/uap_core_chk.sv]
// port checker for the serial unit top
// assumes binding onto uap_core, one clock, synchronous reset
module uap_core_chk
(
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic [15:0] bus_addr_i,
	input wire logic        bus_write_i,
	input wire logic        bus_read_i,
	input wire logic [7:0]  bus_wdata_i,
	input wire logic [7:0]  bus_rdata_o,
	input wire logic        base_tick_i,
	input wire logic [7:0]  baud_divisor_i,
	input wire logic        msb_first_i,
	input wire logic        serial_in_i,
	input wire logic        serial_out_o,
	input wire logic        receive_done_irq_o,
	input wire logic        receive_error_irq_o,
	input wire logic        transmit_done_irq_o
);
	logic [7:0] mode_reg;
	logic       rd_err;
	logic       rd_tx;
	logic       rd_rxb;

	// shadow of the mode register
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			mode_reg <= 8'h01;
		else if (bus_write_i && bus_addr_i == 16'hff50)
			mode_reg <= bus_wdata_i;
	end
	assign rd_err = bus_read_i && bus_addr_i == 16'hff53;
	assign rd_tx = bus_read_i && bus_addr_i == 16'hff55;
	assign rd_rxb = bus_read_i && bus_addr_i == 16'hff52;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	reset_line_a: assert property ($fell(reset_i) |-> serial_out_o)
		else $error("line low after reset");
	power_line_a: assert property (!mode_reg[7] [*3] |-> serial_out_o)
		else $error("line low while unpowered");
	err_route_a: assert property (receive_error_irq_o |-> !mode_reg[0] && !receive_done_irq_o)
		else $error("error interrupt on wrong route");
	done_pulse_a: assert property (transmit_done_irq_o |=> !transmit_done_irq_o)
		else $error("transmit done longer than one cycle");
	done_enable_a: assert property (transmit_done_irq_o |-> mode_reg[7] && mode_reg[6])
		else $error("transmit done while disabled");
	stop_high_a: assert property (transmit_done_irq_o |-> $past(serial_out_o) && $past(serial_out_o, 2))
		else $error("frame ended without high stop");
	off_status_a: assert property ((rd_err || rd_tx) && !mode_reg[7] && !$past(mode_reg[7])
		|=> bus_rdata_o == 8'h00) else $error("status not clear while unpowered");
	off_rxbuf_a: assert property (rd_rxb && !mode_reg[7] && !$past(mode_reg[7])
		|=> bus_rdata_o == 8'hff) else $error("receive buffer not ff while unpowered");
	err_zero_a: assert property (rd_err |=> bus_rdata_o[7:3] == 5'h00)
		else $error("error status upper bits set");
	full_flag_a: assert property (bus_write_i && bus_addr_i == 16'hff51 && mode_reg[7]
		&& mode_reg[6] ##1 !base_tick_i ##1 rd_tx |=> bus_rdata_o[1])
		else $error("buffer full flag not set after write");
endmodule

bind uap_core uap_core_chk u_chk
(
	.clk_i(clk_i), .reset_i(reset_i), .bus_addr_i(bus_addr_i), .bus_write_i(bus_write_i),
	.bus_read_i(bus_read_i), .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o),
	.base_tick_i(base_tick_i), .baud_divisor_i(baud_divisor_i), .msb_first_i(msb_first_i),
	.serial_in_i(serial_in_i), .serial_out_o(serial_out_o),
	.receive_done_irq_o(receive_done_irq_o), .receive_error_irq_o(receive_error_irq_o),
	.transmit_done_irq_o(transmit_done_irq_o)
);

// [testbench/uap_core_tb_top.sv]
// self-checking bench for the serial unit top
// assumes the node model and the bound checker are compiled first
module uap_core_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] addr = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  wdata = 8'h00;
	logic        tick = 1'b0;
	logic        tick_en = 1'b1;
	logic        msb = 1'b0;
	logic [7:0]  rdata;
	logic        sin;
	logic        sout;
	logic        rx_irq;
	logic        er_irq;
	logic        tx_irq;
	logic [7:0]  cur = 8'h01;
	logic [7:0]  v;
	logic [11:0] fa;
	logic [11:0] fb;
	logic        ok;
	int          cnt[4] = '{0, 0, 0, 0};
	int          num_errors = 0;
	int          checks = 0;
	int          n0;

	always #2 clk = ~clk;
	// base tick every other clock, stallable
	always @(posedge clk) tick <= #1 (tick_en & ~tick);
	always @(posedge clk)
	begin
		if (rx_irq) cnt[0]++;
		if (er_irq) cnt[1]++;
		if (tx_irq) cnt[2]++;
		if (rx_irq || er_irq) cnt[3]++;
	end

	uap_core u_dut (.clk_i(clk), .reset_i(rst), .bus_addr_i(addr), .bus_write_i(wr),
		.bus_read_i(rd), .bus_wdata_i(wdata), .bus_rdata_o(rdata), .base_tick_i(tick),
		.baud_divisor_i(8'h04), .msb_first_i(msb), .serial_in_i(sin), .serial_out_o(sout),
		.receive_done_irq_o(rx_irq), .receive_error_irq_o(er_irq), .transmit_done_irq_o(tx_irq));
	uap_node_model #(.BIT_CLKS(8)) u_node (.clk_i(clk), .line_i(sout), .line_o(sin));

	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic timeout();
		num_errors++;
		$display("wait ran out at %0t", $time);
		report_and_stop();
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge clk);
		#1;
		wr = 1'b0;
	endtask

	task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		addr = a;
		rd = 1'b1;
		@(posedge clk);
		#1;
		rd = 1'b0;
		d = rdata;
	endtask

	task automatic expect_reg(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] x;
		rd_reg(a, x);
		check({8'h00, x}, {8'h00, e});
	endtask

	task automatic wait_more(input int k, input int b);
		for (int t = 0; t < 400 && cnt[k] <= b; t++)
			@(posedge clk);
		if (cnt[k] <= b)
			timeout();
	endtask

	// line order: start, data, parity, stops; unused bits high
	function automatic logic [11:0] frame(input logic [7:0] d, input logic [7:0] m,
		input logic ms, input logic bp, input logic bs);
		logic [11:0] f;
		int          n;
		logic        p;
		f = 12'hffe;
		n = 1;
		p = 1'b0;
		for (int i = 0; i < 8; i++)
			if (i < 7 || m[2])
			begin
				f[n] = ms ? d[7 - i] : d[i];
				p ^= f[n];
				n++;
			end
		if (m[4:3] != 2'h0)
		begin
			f[n] = (m[4] ? (m[3] ? p : ~p) : 1'b0) ^ bp;
			n++;
		end
		f[n] = ~bs;
		return f;
	endfunction

	function automatic int flen(input logic [7:0] m);
		return 9 + int'(m[2]) + int'(m[4:3] != 2'h0) + int'(m[1]);
	endfunction

	task automatic set_mode(input logic [7:0] m);
		if (m != cur)
		begin
			wr_reg(16'hff50, 8'h80);
			wr_reg(16'hff50, m);
			cur = m;
		end
	endtask

	task automatic xfer(input logic [7:0] m, input logic [7:0] d, input logic ms);
		int b;
		msb = ms;
		set_mode(m);
		b = cnt[2];
		fork
			wr_reg(16'hff51, d);
			u_node.recv_bits(flen(m), fa, ok);
		join
		if (!ok) timeout();
		check({4'h0, fa}, {4'h0, frame(d, m, ms, 1'b0, 1'b0)});
		wait_more(2, b);
		b = cnt[0];
		u_node.send_bits(frame(d, m, ms, 1'b0, 1'b0), flen(m));
		wait_more(0, b);
		expect_reg(16'hff52, m[2] ? d : (ms ? {d[7:1], 1'b0} : {1'b0, d[6:0]}));
		expect_reg(16'hff53, 8'h00);
		$display("test format %h done", m);
	endtask

	task automatic err_case(input logic [7:0] m, input logic [7:0] d, input logic bp,
		input logic bs, input logic [7:0] st);
		int r;
		int e;
		set_mode(m);
		r = cnt[0];
		e = cnt[1];
		u_node.send_bits(frame(d, m, 1'b0, bp, bs), flen(m));
		wait_more(3, r + e);
		expect_reg(16'hff53, st);
		check(16'(cnt[1] - e), {15'h0, st != 8'h00 && !m[0]});
		check(16'(cnt[0] - r), {15'h0, st == 8'h00 || m[0]});
		$display("test error %h done", st);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b0;
		expect_reg(16'hff50, 8'h01);
		expect_reg(16'hff51, 8'hff);
		expect_reg(16'hff52, 8'hff);
		expect_reg(16'hff53, 8'h00);
		expect_reg(16'hff55, 8'h00);
		expect_reg(16'hff54, 8'h00);
		wr_reg(16'hff52, 8'h5a);
		expect_reg(16'hff52, 8'hff);
		$display("test reset done");
		set_mode(8'h80);
		xfer(8'he4, 8'ha5, 1'b0);
		xfer(8'hec, 8'h3c, 1'b1);
		xfer(8'hf2, 8'hd3, 1'b0);
		xfer(8'hfa, 8'h96, 1'b1);
		xfer(8'hf6, 8'h01, 1'b1);
		xfer(8'hf8, 8'h7e, 1'b0);
		msb = 1'b0;
		err_case(8'hf4, 8'h5b, 1'b1, 1'b0, 8'h04);
		err_case(8'hed, 8'h5b, 1'b1, 1'b0, 8'h00);
		err_case(8'he5, 8'h33, 1'b0, 1'b1, 8'h02);
		expect_reg(16'hff52, 8'h33);
		err_case(8'he5, 8'h11, 1'b0, 1'b0, 8'h00);
		err_case(8'he5, 8'h22, 1'b0, 1'b0, 8'h01);
		expect_reg(16'hff52, 8'h11);
		set_mode(8'he4);
		n0 = cnt[2];
		fork
			begin
				tick_en = 1'b0;
				wr_reg(16'hff51, 8'h55);
				rd_reg(16'hff55, v);
				check({15'h0, v[1]}, 16'h1);
				tick_en = 1'b1;
				repeat (40) if (v[1]) rd_reg(16'hff55, v);
				if (v[1]) timeout();
				wr_reg(16'hff51, 8'h0f);
			end
			begin
				u_node.recv_bits(10, fa, ok);
				if (!ok) timeout();
				u_node.recv_bits(10, fb, ok);
			end
		join
		if (!ok) timeout();
		check({4'h0, fa}, {4'h0, frame(8'h55, 8'he4, 1'b0, 1'b0, 1'b0)});
		check({4'h0, fb}, {4'h0, frame(8'h0f, 8'he4, 1'b0, 1'b0, 1'b0)});
		wait_more(2, n0 + 1);
		check(16'(cnt[2] - n0), 16'h2);
		$display("test continuous done");
		wr_reg(16'hff50, 8'h80);
		wr_reg(16'hff50, 8'h00);
		expect_reg(16'hff52, 8'hff);
		expect_reg(16'hff53, 8'h00);
		expect_reg(16'hff55, 8'h00);
		check({15'h0, sout}, 16'h1);
		$display("test power off done");
		report_and_stop();
	end
endmodule
